// file: common/cscw_pkg.sv
package cscw_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] ERR_OFF = 12'h004;
  localparam logic [11:0] VALID_OFF = 12'h008;
  localparam logic [11:0] STATE_OFF = 12'h00c;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h010;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h014;
  localparam logic [11:0] PD_IN_OFF = 12'h018;
  localparam logic [11:0] LIST_OFF = 12'h100;
  localparam int LIST_DEPTH = 64;
  localparam int LIST_AW = 6;
  localparam int LIST_FIRST_TERM = 2;

  // ==========================================================================
  // field positions and values
  localparam int CTRL_DIS_OUT_BIT = 4;
  localparam int CTRL_SHOW_OVR_BIT = 5;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam int ERR_FAULT_BIT = 0;
  localparam int ERR_OVR_BIT = 1;
  localparam int TYPE_FMT_BIT = 15;
  localparam logic [15:0] ONLINE_USED = 16'hff7f;
  localparam logic [15:0] COUPLER_NAME = 16'h0b01; // arbitrary value
  localparam int IRQ_OVR_BIT = 0;
  localparam int IRQ_INVALID_BIT = 1;
  localparam int IRQ_STATE_BIT = 2;
  localparam int IRQ_SCAN_BIT = 3;
  localparam int IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // slave state codes, low nibble of the online-state word
  localparam logic [3:0] ST_INIT = 4'h1;
  localparam logic [3:0] ST_PREOP = 4'h2;
  localparam logic [3:0] ST_BOOT = 4'h3;
  localparam logic [3:0] ST_SAFEOP = 4'h4;
  localparam logic [3:0] ST_OP = 4'h8;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic is_complex;
    logic [14:0] reg8_type;
    logic [6:0] pd_cfg;
    logic [5:0] sr_ext;
    logic special;
    logic is_output;
  } cscw_term_t;

  typedef struct packed {
    logic [3:0] port;
    logic unexp_link;
    logic miss_link;
    logic link_err;
    logic not_present;
    logic spare;
    logic init_err;
    logic id_err;
    logic slave_err;
    logic [3:0] state;
  } cscw_online_t;

endpackage : cscw_pkg

// file: hdl/cscw_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
module cscw_top import cscw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic scan_start,
  input wire logic term_valid,
  input wire cscw_term_t term_desc,
  input wire logic telegram,
  input wire logic [15:0] pd_out,
  input wire logic wc_invalid,
  input wire cscw_online_t online_in,
  input wire logic coupler_fault,
  input wire logic tb_done,
  input wire logic [15:0] tb_in_data,
  output logic tb_start,
  output logic tb_out_enable,
  output logic [15:0] tb_out_data,
  output logic [15:0] pd_in,
  output logic irq
);

  // ==========================================================================
  // helpers
  function automatic logic [15:0] type_word(input cscw_term_t t);
    if (t.is_complex) begin
      type_word = {1'b0, t.reg8_type};
    end else begin
      type_word = {1'b1, t.pd_cfg, t.sr_ext, t.special, t.is_output};
    end
  endfunction : type_word

  function automatic logic [15:0] online_word(input cscw_online_t o);
    online_word = o & ONLINE_USED;
  endfunction : online_word

  // ==========================================================================
  // terminal list
  logic [15:0] list_mem [0:LIST_DEPTH-1];
  logic [LIST_AW-1:0] count_ff;

  always_ff @(posedge clk) begin
    if (rst || scan_start) begin
      count_ff <= '0;
    end else if (term_valid && count_ff < LIST_AW'(LIST_DEPTH - LIST_FIRST_TERM)) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (term_valid && !scan_start) begin
      list_mem[count_ff + LIST_AW'(LIST_FIRST_TERM)] <= type_word(term_desc);
    end
  end

  // ==========================================================================
  // control word and terminal-bus side
  logic [15:0] ctrl_ff;
  logic tb_busy_ff, tb_start_ff, tb_out_enable_ff;
  logic [15:0] tb_out_data_ff, in_mem_ff, pd_in_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      tb_start_ff <= 1'b0;
      tb_busy_ff <= 1'b0;
    end else begin
      tb_start_ff <= telegram && !tb_busy_ff;
      if (telegram && !tb_busy_ff) begin
        tb_busy_ff <= 1'b1;
      end else if (tb_done) begin
        tb_busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_mem_ff <= '0;
      pd_in_ff <= '0;
    end else begin
      if (tb_done) begin
        in_mem_ff <= tb_in_data;
      end
      if (telegram) begin
        pd_in_ff <= in_mem_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tb_out_enable_ff <= 1'b0;
      tb_out_data_ff <= '0;
    end else begin
      tb_out_enable_ff <= !ctrl_ff[CTRL_DIS_OUT_BIT];
      tb_out_data_ff <= ctrl_ff[CTRL_DIS_OUT_BIT] ? 16'h0000 : pd_out;
    end
  end

  // ==========================================================================
  // status snapshot per telegram
  logic [15:0] err_ff, state_ff, nxt_err;
  logic valid_flag_ff;

  always_comb begin
    nxt_err = ERR_NONE;
    nxt_err[ERR_FAULT_BIT] = coupler_fault;
    nxt_err[ERR_OVR_BIT] = tb_busy_ff && ctrl_ff[CTRL_SHOW_OVR_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      err_ff <= ERR_NONE;
      state_ff <= '0;
      valid_flag_ff <= 1'b0;
    end else if (telegram) begin
      err_ff <= nxt_err;
      state_ff <= online_word(online_in);
      valid_flag_ff <= wc_invalid;
    end
  end

  // ==========================================================================
  // interrupts
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set, irq_clr;
  logic irq_ff;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_OVR_BIT] = telegram && tb_busy_ff;
    irq_set[IRQ_INVALID_BIT] = telegram && wc_invalid;
    irq_set[IRQ_STATE_BIT] = telegram && (online_word(online_in) != state_ff);
    irq_set[IRQ_SCAN_BIT] = scan_start;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      // a new event beats a clear in the same cycle
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
    end
  end

  // ==========================================================================
  // axi4-lite slave
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, aw_hold_ff, w_hold_ff, do_write;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign irq_clr = (do_write && awaddr_ff == IRQ_STAT_OFF && wstrb_ff[0]) ? wdata_ff[IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (awaddr_ff == CTRL_OFF || awaddr_ff == IRQ_STAT_OFF || awaddr_ff == IRQ_MASK_OFF)
          ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
      irq_mask_ff <= '0;
    end else if (do_write && awaddr_ff == CTRL_OFF) begin
      if (wstrb_ff[0]) begin
        ctrl_ff[7:0] <= wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        ctrl_ff[15:8] <= wdata_ff[15:8];
      end
    end else if (do_write && awaddr_ff == IRQ_MASK_OFF && wstrb_ff[0]) begin
      irq_mask_ff <= wdata_ff[IRQ_W-1:0];
    end
  end

  logic [31:0] rd_val;
  logic rd_ok;
  logic [LIST_AW-1:0] rd_idx;
  assign rd_idx = s_axi_araddr[LIST_AW+1:2];

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr >= LIST_OFF && s_axi_araddr < LIST_OFF + 12'(4 * LIST_DEPTH)) begin
      if (rd_idx == '0) begin
        rd_val = {26'h0, count_ff};
      end else if (rd_idx == LIST_AW'(1)) begin
        rd_val = {16'h0000, COUPLER_NAME};
      end else if ({1'b0, rd_idx} < {1'b0, count_ff} + 7'(LIST_FIRST_TERM)) begin
        rd_val = {16'h0000, list_mem[rd_idx]};
      end
    end else begin
      unique case (s_axi_araddr)
        CTRL_OFF: rd_val = {16'h0000, ctrl_ff};
        ERR_OFF: rd_val = {16'h0000, err_ff};
        VALID_OFF: rd_val = {31'h0, valid_flag_ff};
        STATE_OFF: rd_val = {16'h0000, state_ff};
        IRQ_STAT_OFF: rd_val = {28'h0000000, irq_stat_ff};
        IRQ_MASK_OFF: rd_val = {28'h0000000, irq_mask_ff};
        PD_IN_OFF: rd_val = {16'h0000, pd_in_ff};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign tb_start = tb_start_ff;
  assign tb_out_enable = tb_out_enable_ff;
  assign tb_out_data = tb_out_data_ff;
  assign pd_in = pd_in_ff;
  assign irq = irq_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  type_fmt_a: assert property (term_valid && !scan_start && term_desc.is_complex |=>
    list_mem[$past(count_ff) + LIST_AW'(LIST_FIRST_TERM)][TYPE_FMT_BIT] == 1'b0)
    else $error("complex type word has format bit set");
  count_inc_a: assert property (term_valid && !scan_start && count_ff < 6'd62 |=>
    count_ff == $past(count_ff) + 6'd1)
    else $error("terminal count did not advance");
  dig_out_a: assert property (term_valid && !scan_start && !term_desc.is_complex |=>
    list_mem[$past(count_ff) + 6'd2][15] && list_mem[$past(count_ff) + 6'd2][0] == $past(term_desc.is_output))
    else $error("digital type word malformed");
  err_zero_a: assert property (telegram && !coupler_fault && !(tb_busy_ff && ctrl_ff[5]) |=>
    err_ff == 16'h0000)
    else $error("error word not zero without error");
  out_dis_a: assert property (ctrl_ff[4] |=> !tb_out_enable && tb_out_data == 16'h0000)
    else $error("outputs active while disabled");
  ovr_show_a: assert property (telegram && tb_busy_ff |=> err_ff[1] == $past(ctrl_ff[5]))
    else $error("overrun display wrong");
  valid_flag_a: assert property (telegram |=> valid_flag_ff == $past(wc_invalid))
    else $error("validity flag not sampled");
  state_word_a: assert property (telegram |=> state_ff[3:0] == $past(online_in.state)
    && state_ff[6:4] == {$past(online_in.init_err), $past(online_in.id_err), $past(online_in.slave_err)}
    && !state_ff[7] && state_ff[11:8] == $past(online_in[11:8]) && state_ff[15:12] == $past(online_in.port))
    else $error("online word encoding wrong");
  hold_a: assert property (!telegram |=> $stable(state_ff) && $stable(err_ff))
    else $error("status changed between telegrams");
  input_age_a: assert property (tb_done ##1 !tb_done [*1] ##0 telegram |=> pd_in == $past(tb_in_data, 2))
    else $error("latched inputs not returned");
  start_a: assert property (telegram && !tb_busy_ff |=> tb_start ##1 !tb_start)
    else $error("terminal bus cycle not started");

  overrun_c: cover property (telegram && tb_busy_ff ##1 err_ff[1]);
  scan_c: cover property (scan_start ##2 term_valid);
  write_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  irq_c: cover property (!irq ##1 irq);

endmodule : cscw_top

// file: verification/cscw_tbus_model.sv
module cscw_tbus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic tb_start,
  input wire logic slow,
  input wire logic [15:0] next_data,
  output logic tb_done,
  output logic [15:0] tb_in_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // terminal bus: one cycle per start, prompt or slow
  int cnt_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 0;
      tb_done <= 1'b0;
      tb_in_data <= 16'h0000;
    end else begin
      tb_done <= (cnt_ff == 1);
      // data only means something with done, so it never holds still
      tb_in_data <= (cnt_ff == 1) ? next_data : ~tb_in_data;
      if (tb_start) begin
        cnt_ff <= slow ? 40 : 3;
      end else if (cnt_ff > 0) begin
        cnt_ff <= cnt_ff - 1;
      end
    end
  end
endmodule : cscw_tbus_model

// file: verification/testbench.sv
module testbench import cscw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scan_start, term_valid, telegram;
  logic wc_invalid, coupler_fault, tb_done, tb_start, tb_out_enable, irq, slow;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] pd_out, tb_in_data, tb_out_data, pd_in, next_data, nd, prev;
  cscw_term_t term_desc, t;
  cscw_online_t online_in, o;
  logic [3:0] states [5] = '{ST_INIT, ST_PREOP, ST_BOOT, ST_SAFEOP, ST_OP};
  int mismatches, n_compared;
  int exp_list[$];

  cscw_top dut (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .scan_start, .term_valid, .term_desc, .telegram, .pd_out, .wc_invalid,
    .online_in, .coupler_fault, .tb_done, .tb_in_data, .tb_start, .tb_out_enable, .tb_out_data,
    .pd_in, .irq);
  cscw_tbus_model tbus (.clk, .rst, .tb_start, .slow, .next_data, .tb_done, .tb_in_data);

  // ==========================================================
  // bus cycles and comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic tel();
    @(posedge clk);
    telegram <= 1'b1;
    @(posedge clk);
    telegram <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : tel

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #40000;
    mismatches++;
    complete_run();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, scan_start} = '0;
    {term_valid, telegram, wc_invalid, coupler_fault, slow, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, term_desc, pd_out, online_in, next_data, prev} = '0;
    s_axi_wstrb = 4'hf;
    rst = 1'b1;
    void'($urandom(37));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axr(CTRL_OFF, rd);
    chk("ctrl", {16'h0, CTRL_RESET}, rd);
    axr(ERR_OFF, rd);
    chk("err", {16'h0, ERR_NONE}, rd);
    axw(ERR_OFF, 32'h1, RESP_SLVERR);
    axr(12'h0fc, rd);
    chk("unmapped", 32'h0, rd);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    $display("test reset done");
    // list of three terminals, middle one complex
    @(posedge clk);
    scan_start <= 1'b1;
    @(posedge clk);
    scan_start <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      t = cscw_term_t'(31'($urandom));
      t.is_complex = (i == 1);
      exp_list.push_back(t.is_complex ? {1'b0, t.reg8_type} : {1'b1, t.pd_cfg, t.sr_ext, t.special, t.is_output});
      @(posedge clk);
      term_desc <= t;
      term_valid <= 1'b1;
      @(posedge clk);
      term_valid <= 1'b0;
    end
    axr(LIST_OFF, rd);
    chk("count", 32'd3, rd);
    axr(LIST_OFF + 12'h004, rd);
    chk("name", {16'h0, COUPLER_NAME}, rd);
    for (int k = 0; k < 4; k++) begin
      axr(LIST_OFF + 12'(4 * (k + LIST_FIRST_TERM)), rd);
      chk("type", (k < 3) ? 32'(exp_list[k]) : 32'h0, rd);
    end
    $display("test list done");
    // output disable and release
    nd = 16'($urandom);
    pd_out <= nd;
    axw(CTRL_OFF, 32'h10, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("out_en", 32'h0, {31'h0, tb_out_enable});
    chk("out_data", 32'h0, {16'h0, tb_out_data});
    axw(CTRL_OFF, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("out_en", 32'h1, {31'h0, tb_out_enable});
    chk("out_data", {16'h0, nd}, {16'h0, tb_out_data});
    $display("test outputs done");
    // every state code with random flags
    for (int i = 0; i < 5; i++) begin
      o = cscw_online_t'(16'($urandom));
      o.state = states[i];
      nd = 16'($urandom);
      online_in <= o;
      wc_invalid <= i[0];
      next_data <= nd;
      tel();
      chk("pd_in", {16'h0, prev}, {16'h0, pd_in});
      tel();
      chk("pd_in", {16'h0, nd}, {16'h0, pd_in});
      prev = nd;
      online_in <= ~o;
      axr(STATE_OFF, rd);
      chk("state", {16'h0, o[15:8], 1'b0, o[6:0]}, rd);
      axr(VALID_OFF, rd);
      chk("valid", 32'(i[0]), rd);
    end
    $display("test online done");
    // overrun shown, irq masked, raised, cleared
    wc_invalid <= 1'b0;
    axw(IRQ_STAT_OFF, 32'hf, RESP_OKAY);
    axw(CTRL_OFF, 32'h20, RESP_OKAY);
    slow <= 1'b1;
    coupler_fault <= 1'b1;
    tel();
    tel();
    axr(ERR_OFF, rd);
    chk("err", 32'h3, rd);
    axr(IRQ_STAT_OFF, rd);
    chk("irq_stat", 32'h1 << IRQ_OVR_BIT | 32'h1 << IRQ_STATE_BIT, rd);
    chk("irq", 32'h0, {31'h0, irq});
    axw(IRQ_MASK_OFF, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    axw(IRQ_STAT_OFF, rd, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    repeat (50) @(posedge clk);
    axw(CTRL_OFF, 32'h0, RESP_OKAY);
    tel();
    tel();
    axr(ERR_OFF, rd);
    chk("err", 32'h1, rd);
    $display("test overrun done");
    complete_run();
  end
endmodule : testbench
